// ===== shared/afsc_pkg.sv
package afsc_pkg;
   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int          NUM_SETUPS     = 8;
   localparam logic [7:0]  CFG_BASE_ADDR  = 8'h28;
   localparam logic [7:0]  CFG_LAST_ADDR  = 8'h2f;
   localparam logic [15:0] CFG_RESET      = 16'h0500;
   // Reserved [14:12] and 7 masked off in normal mapping
   localparam logic [15:0] CFG_WMASK_NORM = 16'h8f7f;
   localparam logic [15:0] CFG_WMASK_DIR  = 16'hffff;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int DIRECT_BIT   = 15;
   localparam int RATIO_MSB    = 14;
   localparam int POST_EN_BIT  = 11;
   localparam int POST_SEL_MSB = 10;
   localparam int POST_SEL_LSB = 8;
   localparam int ORDER_MSB    = 6;
   localparam int ORDER_LSB    = 5;
   localparam int RATE_MSB     = 4;

   // ***************************************************************
   // Field encodings
   // ***************************************************************
   localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
   localparam logic [1:0] ORDER_SINC3       = 2'h3;
   localparam logic [2:0] POST_27SPS        = 3'h2;
   localparam logic [2:0] POST_21SPS        = 3'h3;
   localparam logic [2:0] POST_20SPS        = 3'h5;
   localparam logic [2:0] POST_16SPS        = 3'h6;
   localparam logic [4:0] RATE_31250SPS     = 5'h00;

   // Log2 of the modulator samples per decimation unit in direct mode (32 samples)
   localparam int DECIM_SHIFT = 5;
   localparam int DECIM_CNT_W = RATIO_MSB + 1 + DECIM_SHIFT;

   typedef enum logic [1:0]
   {
      SEQ_RUN   = 2'b01,
      SEQ_ABORT = 2'b10
   } afsc_seq_type;
endpackage

// ===== src/afsc_rate_gen.sv
`timescale 1ns/1ps
module afsc_rate_gen
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_mod_en,
   input  wire logic        i_enable,
   input  wire logic        i_restart,
   input  wire logic [14:0] i_ratio,
   output logic             o_word_tick
);
   import afsc_pkg::*;

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed
   {
      logic [DECIM_CNT_W-1:0] cnt;
      logic                   tick;
   } afsc_rg_state_type;

   afsc_rg_state_type s_q;
   afsc_rg_state_type s_d;
   logic [DECIM_CNT_W-1:0] period;

   // Period of 32 x ratio modulator samples
   assign period = {i_ratio, {DECIM_SHIFT{1'b0}}};

   always_comb
   begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      // Ratio zero would give no defined rate, so it stays silent
      if (i_restart || !i_enable || (i_ratio == 15'h0000))
      begin
         s_d.cnt = '0;
      end
      else if (i_mod_en)
      begin
         if (s_q.cnt == period - 1'b1)
         begin
            s_d.cnt  = '0;
            s_d.tick = 1'b1;
         end
         else
         begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_word_tick = s_q.tick;

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_tick_gap;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_word_tick |=> !o_word_tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("word ticks too close");

   property p_tick_count;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_word_tick) |-> ($past(s_q.cnt) == period - 1'b1);
   endproperty
   a_tick_count: assert property (p_tick_count) else $error("tick not at 32 x ratio");
endmodule

// ===== src/afsc_top.sv
`timescale 1ns/1ps
module afsc_top
#(
   parameter int N_SETUPS = afsc_pkg::NUM_SETUPS
)
(
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_mod_en,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic [2:0]  i_setup_sel,
   output logic      [15:0] o_rdata,
   output logic             o_rd_valid,
   output logic             o_abort,
   output logic             o_restart_first,
   output logic      [2:0]  o_written_setup,
   output logic             o_direct_mode,
   output logic      [14:0] o_decim_ratio,
   output logic             o_post_active,
   output logic      [2:0]  o_post_select,
   output logic      [1:0]  o_order,
   output logic      [4:0]  o_rate_code,
   output logic             o_word_tick
);
   import afsc_pkg::*;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic fn_hit(input logic [7:0] addr);
      fn_hit = (addr >= CFG_BASE_ADDR) && (addr <= CFG_LAST_ADDR);
   endfunction

   function automatic logic [2:0] fn_index(input logic [7:0] addr);
      logic [7:0] off;
      off      = addr - CFG_BASE_ADDR;
      fn_index = off[2:0];
   endfunction

   // Direct mapping owns all of [14:0], so nothing is masked there
   function automatic logic [15:0] fn_mask(input logic [15:0] data);
      fn_mask = data & (data[DIRECT_BIT] ? CFG_WMASK_DIR : CFG_WMASK_NORM);
   endfunction

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_sync_q <= 2'b00;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed
   {
      afsc_seq_type                st;
      logic [N_SETUPS-1:0][15:0]   cfg;
      logic [15:0]                 rdata;
      logic                        rd_valid;
      logic                        abort;
      logic                        restart;
      logic [2:0]                  wr_setup;
      logic                        direct;
      logic [14:0]                 ratio;
      logic                        post_act;
      logic [2:0]                  post_sel;
      logic [1:0]                  order;
      logic [4:0]                  rate;
   } afsc_top_state_type;

   afsc_top_state_type s_q;
   afsc_top_state_type s_d;
   logic               wr_hit;
   logic               rd_hit;
   logic [15:0]        sel_cfg;
   logic               tick;

   assign wr_hit  = i_wr_en && fn_hit(i_addr);
   assign rd_hit  = i_rd_en && fn_hit(i_addr);
   assign sel_cfg = s_q.cfg[i_setup_sel];

   always_comb
   begin
      s_d          = s_q;
      s_d.rd_valid = i_rd_en;
      s_d.abort    = 1'b0;
      s_d.restart  = 1'b0;

      // Register access, unmapped reads give zero
      if (wr_hit)
      begin
         s_d.cfg[fn_index(i_addr)] = fn_mask(i_wdata);
         s_d.wr_setup              = fn_index(i_addr);
      end
      if (i_rd_en)
      begin
         s_d.rdata = rd_hit ? s_q.cfg[fn_index(i_addr)] : 16'h0000;
      end

      // Abort then restart; back to back writes hold the abort
      case (s_q.st)
         SEQ_RUN:
         begin
            if (wr_hit)
            begin
               s_d.st    = SEQ_ABORT;
               s_d.abort = 1'b1;
            end
         end
         SEQ_ABORT:
         begin
            if (wr_hit)
            begin
               s_d.abort = 1'b1;
            end
            else
            begin
               s_d.st      = SEQ_RUN;
               s_d.restart = 1'b1;
            end
         end
         default:
         begin
            s_d.st = SEQ_RUN;
         end
      endcase

      // Effective settings of the selected setup
      s_d.direct = sel_cfg[DIRECT_BIT];
      s_d.ratio  = sel_cfg[RATIO_MSB:0];
      if (sel_cfg[DIRECT_BIT])
      begin
         s_d.post_act = 1'b0;
         s_d.post_sel = 3'h0;
         s_d.order    = ORDER_SINC3;
         s_d.rate     = RATE_31250SPS;
      end
      else
      begin
         s_d.post_act = sel_cfg[POST_EN_BIT] &&
                        (sel_cfg[ORDER_MSB:ORDER_LSB] == ORDER_SINC5_SINC1);
         s_d.post_sel = sel_cfg[POST_SEL_MSB:POST_SEL_LSB];
         s_d.order    = sel_cfg[ORDER_MSB:ORDER_LSB];
         s_d.rate     = sel_cfg[RATE_MSB:0];
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q          <= '0;
         s_q.st       <= SEQ_RUN;
         s_q.cfg      <= {N_SETUPS{CFG_RESET}};
         s_q.post_sel <= CFG_RESET[POST_SEL_MSB:POST_SEL_LSB];
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Direct decimation word rate
   // ***************************************************************
   // Counter clears on abort so the first word after a write is whole
   afsc_rate_gen u_rate_gen
   (
      .i_clk       (i_clk),
      .i_rst_n     (rst_n),
      .i_mod_en    (i_mod_en),
      .i_enable    (s_q.direct),
      .i_restart   (s_q.abort),
      .i_ratio     (s_q.ratio),
      .o_word_tick (tick)
   );

   assign o_rdata         = s_q.rdata;
   assign o_rd_valid      = s_q.rd_valid;
   assign o_abort         = s_q.abort;
   assign o_restart_first = s_q.restart;
   assign o_written_setup = s_q.wr_setup;
   assign o_direct_mode   = s_q.direct;
   assign o_decim_ratio   = s_q.ratio;
   assign o_post_active   = s_q.post_act;
   assign o_post_select   = s_q.post_sel;
   assign o_order         = s_q.order;
   assign o_rate_code     = s_q.rate;
   assign o_word_tick     = tick;

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_wr_abort;
      @(posedge i_clk) disable iff (!rst_n)
      wr_hit |=> o_abort && !o_restart_first;
   endproperty
   a_wr_abort: assert property (p_wr_abort) else $error("write did not abort");

   property p_restart;
      @(posedge i_clk) disable iff (!rst_n)
      (wr_hit ##1 !wr_hit) |=> o_restart_first ##1 !o_restart_first;
   endproperty
   a_restart: assert property (p_restart) else $error("no single restart");

   property p_reset_value;
      @(posedge i_clk)
      $rose(rst_n) |-> (s_q.cfg[0] == CFG_RESET) && (s_q.cfg[N_SETUPS-1] == CFG_RESET);
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("bad reset value");

   property p_direct_ignore;
      @(posedge i_clk) disable iff (!rst_n)
      o_direct_mode |-> !o_post_active && (o_decim_ratio == $past(sel_cfg[RATIO_MSB:0]));
   endproperty
   a_direct_ignore: assert property (p_direct_ignore) else $error("direct mode fields");

   property p_reserved;
      @(posedge i_clk) disable iff (!rst_n)
      rd_hit |=> !o_rdata[7] || o_rdata[DIRECT_BIT];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit read back");

   property p_post_order;
      @(posedge i_clk) disable iff (!rst_n)
      o_post_active |-> (o_order == ORDER_SINC5_SINC1) && !o_direct_mode;
   endproperty
   a_post_order: assert property (p_post_order) else $error("postfilter with wrong order");

   property p_fields_reset;
      @(posedge i_clk)
      $rose(rst_n) |-> (s_q.cfg[0][POST_SEL_MSB:POST_SEL_LSB] == POST_20SPS) &&
         (s_q.cfg[0][ORDER_MSB:ORDER_LSB] == ORDER_SINC5_SINC1) &&
         (s_q.cfg[0][RATE_MSB:0] == RATE_31250SPS);
   endproperty
   a_fields_reset: assert property (p_fields_reset) else $error("field reset values");

   property p_readback;
      @(posedge i_clk) disable iff (!rst_n)
      (wr_hit && !i_rd_en) ##1 (rd_hit && !wr_hit && (i_addr == $past(i_addr)))
      |=> o_rdata == fn_mask($past(i_wdata, 2));
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch");

   property p_unmapped;
      @(posedge i_clk) disable iff (!rst_n)
      (i_rd_en && !rd_hit) |=> (o_rdata == 16'h0000) && o_rd_valid;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ===== tb/afsc_host_model.sv
`timescale 1ns/1ps
module afsc_host_model
   import afsc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_rd_valid,
   output logic             o_wr_en,
   output logic             o_rd_en,
   output logic      [7:0]  o_addr,
   output logic      [15:0] o_wdata
);
   // ***************************************************************
   // Register port master
   // ***************************************************************
   initial
   begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 8'h00;
      o_wdata = 16'h0000;
   end

   // Released bus scrambled so stale values never pass as answers
   task automatic idle();
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = ~o_addr;
      o_wdata = ~o_wdata;
      @(posedge i_clk);
      #2;
   endtask

   // Strobe held one edge; caller may chain writes back to back
   task automatic wr_raw(input logic [7:0] a, input logic [15:0] d);
      o_wr_en = 1'b1;
      o_addr  = a;
      o_wdata = d;
      @(posedge i_clk);
      #2;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wr_raw(a, d[15] ? d : (d & CFG_WMASK_NORM));
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
      // Ends a chained write so the read stands alone
      o_wr_en = 1'b0;
      o_rd_en = 1'b1;
      o_addr  = a;
      @(posedge i_clk);
      #2;
      d = i_rdata;
      v = i_rd_valid;
      idle();
   endtask
endmodule

// ===== tb/test_adc_filter_setup_config.sv
`timescale 1ns/1ps
module test_adc_filter_setup_config;
   import afsc_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        mod_en = 1'b0;
   logic [2:0]  sel = 3'h0;
   logic        wr_en, rd_en, rd_valid, abort, restart, direct, post_act, tick;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic [2:0]  wsetup, post_sel;
   logic [14:0] ratio;
   logic [1:0]  order;
   logic [4:0]  rate;
   int          fails = 0;
   int          tests_run = 0;

   always #12.5 clk = ~clk;

   afsc_top u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_mod_en(mod_en), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_setup_sel(sel), .o_rdata(rdata),
      .o_rd_valid(rd_valid), .o_abort(abort), .o_restart_first(restart),
      .o_written_setup(wsetup), .o_direct_mode(direct), .o_decim_ratio(ratio),
      .o_post_active(post_act), .o_post_select(post_sel), .o_order(order),
      .o_rate_code(rate), .o_word_tick(tick));

   afsc_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
      .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

   // ***************************************************************
   // Shared helpers
   // ***************************************************************
   task automatic stop_test();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic eff(input logic [14:0] exp);
      chk("effective", {1'b0, direct, post_act, order, post_sel, rate, 3'h0}, {1'b0, exp});
   endtask

   task automatic wait_tick(output int n);
      n = 0;
      while (tick !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         #2;
         n++;
      end
      if (n >= 400)
      begin
         fails++;
         stop_test();
      end
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_reset();
      logic [15:0] d;
      logic        v;
      eff({1'b0, 1'b0, 2'h0, 3'h5, 5'h00, 3'h0});
      for (int i = 0; i < NUM_SETUPS; i++)
      begin
         u_host.rd(8'(CFG_BASE_ADDR + i), d, v);
         chk("cfg_reset", d, CFG_RESET);
         chk("rd_valid", {15'h0000, v}, 16'h0001);
      end
      u_host.rd(8'h30, d, v);
      chk("unmapped", {v, d[14:0]}, 16'h8000);
   endtask

   task automatic t_abort();
      logic [15:0] d;
      logic        v;
      u_host.wr(8'h2a, 16'h0123);
      chk("abort1", {abort, restart, 11'h0, wsetup}, 16'h8002);
      u_host.wr_raw(8'h2f, 16'h7fff);
      chk("abort2", {abort, restart, 11'h0, wsetup}, 16'h8007);
      u_host.idle();
      chk("restart", {14'h0000, abort, restart}, 16'h0001);
      u_host.wr_raw(8'h30, 16'h1234);
      u_host.idle();
      chk("no_abort", {14'h0000, abort, restart}, 16'h0000);
      u_host.rd(8'h2f, d, v);
      chk("reserved", d, 16'h0f7f);
      u_host.rd(8'h2a, d, v);
      chk("readback", d, 16'h0123);
   endtask

   task automatic t_fields();
      logic [15:0] w [6] = '{16'h0a1f, 16'h0b1f, 16'h0d1f, 16'h0e1f, 16'h0d60, 16'h0505};
      // Expected {direct, post_act, order, post_sel, rate, 3'h0}
      logic [14:0] e [6] = '{15'h22f8, 15'h23f8, 15'h25f8, 15'h26f8, 15'h1d00, 15'h0528};
      sel = 3'h0;
      for (int i = 0; i < 6; i++)
      begin
         u_host.wr(8'h28, w[i]);
         u_host.idle();
         eff(e[i]);
      end
   endtask

   task automatic t_direct();
      logic [15:0] d;
      logic        v;
      int          n;
      sel = 3'h3;
      u_host.wr(8'h2b, 16'h8002);
      u_host.idle();
      eff({1'b1, 1'b0, 2'h3, 3'h0, 5'h00, 3'h0});
      chk("ratio", {1'b0, ratio}, 16'h0002);
      u_host.wr(8'h2d, 16'hf0ff);
      u_host.rd(8'h2d, d, v);
      chk("direct_rb", d, 16'hf0ff);
      mod_en = 1'b1;
      wait_tick(n);
      @(posedge clk);
      #2;
      wait_tick(n);
      chk("period", 16'(n + 1), 16'd64);
      mod_en = 1'b0;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      #2;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      t_reset();
      t_abort();
      t_fields();
      t_direct();
      stop_test();
   end
endmodule
